// file: rsci_pkg.sv
// rsci_pkg.sv: constants, field layout and state type of the strap block
// assumes: one 50 MHz clock; ahb-lite register window of 256 bytes

package rsci_pkg;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  // shortest reset pulse the board must give; nothing inside measures it
  localparam int unsigned RST_MIN_NS    = 1000;
  localparam int unsigned RST_MIN_CYC   =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ******************************************************************
  // synchroniser bundle layout
  // ******************************************************************
  localparam int SYN_PIN      = 0;
  localparam int SYN_STRAP_HI = 1;
  localparam int SYN_SEL_LO   = 2;
  localparam int SYN_SEL_MID  = 3;
  localparam int SYN_SEL_HI   = 4;
  localparam int SYN_SUPPLY   = 5;
  localparam int SYN_W        = 6;
  localparam int SEL_W        = 3;

  // ******************************************************************
  // configuration method and fixed-device codes
  // ******************************************************************
  localparam logic [2:0] CFG_DEFAULT     = 3'h0;
  localparam logic [2:0] CFG_SMBUS       = 3'h1;
  localparam logic [2:0] CFG_DEFAULT_BUS = 3'h2;
  localparam logic [6:0] SMB_SLAVE_ADDR  = 7'h2c;
  localparam logic [1:0] FIX_NONE        = 2'h0;
  localparam logic [1:0] FIX_P1          = 2'h1;
  localparam logic [1:0] FIX_P12         = 2'h2;
  localparam logic [1:0] FIX_P123        = 2'h3;
  localparam int         FIX_POL_BIT     = 0;
  localparam logic [2:0] NONREM_NONE     = 3'h0;
  localparam logic [2:0] NONREM_P1       = 3'h1;
  localparam logic [2:0] NONREM_P12      = 3'h3;
  localparam logic [2:0] NONREM_P123     = 3'h7;

  // ******************************************************************
  // bus and register map
  // ******************************************************************
  localparam int         HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  localparam logic       HRESP_OKAY     = 1'h0;
  localparam int         OFS_W          = 8;
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_SMB        = 8'h08;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam int CTRL_CONF_BIT   = 0;
  localparam int CTRL_SUSP_BIT   = 1;
  localparam int ST_CFG_LSB      = 0;
  localparam int ST_FIX_LSB      = 3;
  localparam int ST_STRAPEN_BIT  = 5;
  localparam int ST_NONREM_LSB   = 6;
  localparam int ST_POLLOW_BIT   = 9;
  localparam int ST_SELFPWR_BIT  = 10;
  localparam int ST_DONE_BIT     = 11;
  localparam int ST_SMB_BIT      = 12;
  localparam int ST_LED_BIT      = 13;
  localparam int ST_SUPPLY_BIT   = 14;
  localparam int SMB_ADDR_LSB    = 0;
  localparam int SMB_EN_BIT      = 7;

  typedef enum logic [1:0] {
    RSCI_HOLD,
    RSCI_CAPTURE,
    RSCI_RUN
  } rsci_state_t;

endpackage

// file: rsci_sync_if.sv
// rsci_sync_if.sv: bundle of asynchronous levels and their synced copies
// assumes: one synchroniser drives sync_out, one user drives async_in
`timescale 1ns/1ps

interface rsci_sync_if #(
  parameter int W = 1
) ();
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;
  modport sync_mp (input async_in, output sync_out);
  modport user_mp (output async_in, input sync_out);
endinterface

// file: rsci_sync.sv
// rsci_sync.sv: two-stage synchroniser for a bundle of pin levels
// assumes: inputs change freely against sys_clk; rstn asynchronous
`timescale 1ns/1ps

module rsci_sync #(
  parameter int W = 1
) (
  input wire logic    sys_clk,
  input wire logic    rstn,
  rsci_sync_if.sync_mp port
);
  logic [W-1:0] stage_a;
  logic [W-1:0] stage_b;

  // stage_a is read by stage_b alone: it may still be metastable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage_a <= '0;
      stage_b <= '0;
    end else begin
      stage_a <= port.async_in;
      stage_b <= stage_a;
    end
  end

  assign port.sync_out = stage_b;
endmodule

// file: rsci_strap_capture.sv
// rsci_strap_capture.sv: strap capture at reset release, config method
// decode, shared status pin and its ahb-lite register window
// assumes: strap and supply inputs are asynchronous pins; the pad ring
// resolves the shared pin from hub_active_led_oe; hsel covers 256 bytes
// ********************************************************************
// Overview of operation
// (R01) latch high config select at reset release
// (R02) missing high select pin reads as zero
// (R03) board supplies the reference clock
// (R04) reset input low holds all logic reset
// (R05) board holds external reset low long enough
// (R06) internal reset held until supplies stable
// (R07) indicator active only configured and awake
// (R08) shared pin low means bus powered
// (R09) fixed-device straps sampled only when enabled
// (R10) code 00: all removable, indicator active high
// (R11) code 01: port 1 fixed, active low
// (R12) code 10: ports 1-2 fixed, active high
// (R13) code 11: ports 1-3 fixed, active low
// (R14) three select pins form method code
// (R15) method 000: defaults with straps enabled
// (R16) method 001: management slave, straps off
// (R17) captured values frozen until next reset
// (R18) shared pin undriven until straps sampled
// ********************************************************************
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module rsci_strap_capture #(
  parameter bit HAS_SEL_HI = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        supply_stable,
  input  wire logic        config_method_select_hi,
  input  wire logic        config_method_select_mid,
  input  wire logic        config_method_select_lo,
  input  wire logic        fixed_device_strap_hi,
  input  wire logic        self_power_detect,
  output logic             hub_active_led,
  output logic             hub_active_led_oe,
  output logic [2:0]       config_method,
  output logic [1:0]       fixed_device_code,
  output logic [2:0]       non_removable_ports,
  output logic             led_active_low,
  output logic             self_power,
  output logic             smbus_slave_mode,
  output logic             strap_enable,
  output logic             capture_done,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // ******************************************************************
  // input synchronisers
  // ******************************************************************
  rsci_sync_if #(.W(rsci_pkg::SYN_W)) pins ();

  logic [rsci_pkg::SYN_W-1:0] pin_sync;
  logic                       sel_hi_eff;
  logic                       supply_ok;
  logic [2:0]                 sel_now;
  logic                       strap_hi_now;
  logic                       strap_lo_now;

  // a package without the pin ties it low before the synchroniser
  assign sel_hi_eff = HAS_SEL_HI ? config_method_select_hi : 1'h0; // R02

  assign pins.async_in = {supply_stable,
                          sel_hi_eff,
                          config_method_select_mid,
                          config_method_select_lo,
                          fixed_device_strap_hi,
                          self_power_detect};

  rsci_sync #(.W(rsci_pkg::SYN_W)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .port    (pins.sync_mp)
  );

  assign pin_sync     = pins.sync_out;
  assign supply_ok    = pin_sync[rsci_pkg::SYN_SUPPLY]; // R06
  assign sel_now      = pin_sync[rsci_pkg::SYN_SEL_HI -: rsci_pkg::SEL_W];
  assign strap_hi_now = pin_sync[rsci_pkg::SYN_STRAP_HI];
  assign strap_lo_now = pin_sync[rsci_pkg::SYN_PIN];

  // ******************************************************************
  // method decode and strap code ahead of capture
  // ******************************************************************
  logic       strap_en_now;
  logic       smb_now;
  logic [1:0] fix_now;
  logic [2:0] nonrem_now;
  logic       selfpwr_now;

  assign strap_en_now = (sel_now == rsci_pkg::CFG_DEFAULT) // R15
                      | (sel_now == rsci_pkg::CFG_DEFAULT_BUS);
  assign smb_now      = (sel_now == rsci_pkg::CFG_SMBUS); // R16
  // straps off: fall back to all removable, indicator active high
  assign fix_now      = strap_en_now ? {strap_hi_now, strap_lo_now} // R09
                                     : rsci_pkg::FIX_NONE;
  assign nonrem_now   =
    (fix_now == rsci_pkg::FIX_P123) ? rsci_pkg::NONREM_P123 : // R13
    (fix_now == rsci_pkg::FIX_P12)  ? rsci_pkg::NONREM_P12  : // R12
    (fix_now == rsci_pkg::FIX_P1)   ? rsci_pkg::NONREM_P1   : // R11
                                      rsci_pkg::NONREM_NONE;  // R10
  // bus-powered method forces bus power whatever the pin reads
  assign selfpwr_now  = strap_lo_now // R08
                      & (sel_now != rsci_pkg::CFG_DEFAULT_BUS);

  // ******************************************************************
  // reset release sequence
  // ******************************************************************
  rsci_pkg::rsci_state_t state;
  rsci_pkg::rsci_state_t next_state;

  // supply_ok rises two edges after release, so the other synced pins
  // have settled by then; capture lands two edges after that rise
  always_comb begin
    next_state = state;
    case (state)
      rsci_pkg::RSCI_HOLD: begin
        if (supply_ok) begin
          next_state = rsci_pkg::RSCI_CAPTURE; // R06
        end
      end
      rsci_pkg::RSCI_CAPTURE: begin
        next_state = rsci_pkg::RSCI_RUN;
      end
      rsci_pkg::RSCI_RUN: begin
        next_state = rsci_pkg::RSCI_RUN;
      end
      default: begin
        next_state = rsci_pkg::RSCI_HOLD;
      end
    endcase
    if (!supply_ok) begin
      next_state = rsci_pkg::RSCI_HOLD; // R06
    end
  end

  // external reset pulse width is the board's job
  always_ff @(posedge sys_clk or negedge rstn) begin // R05
    if (!rstn) begin
      state <= rsci_pkg::RSCI_HOLD; // R04
    end else begin
      state <= next_state;
    end
  end

  // ******************************************************************
  // captured straps
  // ******************************************************************
  // loaded once per reset and again after each supply loss; pin changes afterwards never reach them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      config_method       <= rsci_pkg::CFG_DEFAULT; // R04
      fixed_device_code   <= rsci_pkg::FIX_NONE;
      non_removable_ports <= rsci_pkg::NONREM_NONE;
      led_active_low      <= 1'h0;
      self_power          <= 1'h0;
      smbus_slave_mode    <= 1'h0;
      strap_enable        <= 1'h0;
      capture_done        <= 1'h0;
    end else if (state == rsci_pkg::RSCI_HOLD) begin
      config_method       <= rsci_pkg::CFG_DEFAULT;
      fixed_device_code   <= rsci_pkg::FIX_NONE;
      non_removable_ports <= rsci_pkg::NONREM_NONE;
      led_active_low      <= 1'h0;
      self_power          <= 1'h0;
      smbus_slave_mode    <= 1'h0;
      strap_enable        <= 1'h0;
      capture_done        <= 1'h0;
    end else if (state == rsci_pkg::RSCI_CAPTURE) begin // R17
      config_method       <= sel_now; // R01 R14
      fixed_device_code   <= fix_now; // R09
      non_removable_ports <= nonrem_now;
      led_active_low      <= fix_now[rsci_pkg::FIX_POL_BIT]; // R10 R11
      self_power          <= selfpwr_now; // R08
      smbus_slave_mode    <= smb_now; // R16
      strap_enable        <= strap_en_now;
      capture_done        <= 1'h1;
    end
  end

  // ******************************************************************
  // hub state bits and shared indicator pin
  // ******************************************************************
  logic hub_configured;
  logic hub_suspended;
  logic led_on;
  logic next_led;

  assign led_on   = (state == rsci_pkg::RSCI_RUN) // R07
                  & hub_configured & ~hub_suspended;
  assign next_led = led_on ^ led_active_low; // R12 R13

  // pin stays an input until the straps are in, so a strap resistor
  // is never fought by our own driver
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hub_active_led    <= 1'h0;
      hub_active_led_oe <= 1'h0;
    end else begin
      hub_active_led    <= next_led;
      hub_active_led_oe <= (state == rsci_pkg::RSCI_RUN); // R18
    end
  end

  // ******************************************************************
  // ahb-lite slave: zero wait states, always okay
  // ******************************************************************
  logic                       ahb_take;
  logic                       ahb_word;
  logic [rsci_pkg::OFS_W-1:0] ahb_ofs;
  logic                       wr_pend;
  logic [rsci_pkg::OFS_W-1:0] wr_ofs;
  logic                       wr_ctrl;
  logic [31:0]                ctrl_word;
  logic [31:0]                status_word;
  logic [31:0]                smb_word;
  logic [31:0]                rd_value;

  assign hreadyout = 1'h1;
  assign hresp     = rsci_pkg::HRESP_OKAY;
  assign ahb_take  = hsel & htrans[rsci_pkg::HTRANS_ACT_BIT] & hready;
  assign ahb_word  = (hsize == rsci_pkg::HSIZE_WORD);
  assign ahb_ofs   = haddr[rsci_pkg::OFS_W-1:0];
  // hub state bits only take writes once the straps are in
  assign wr_ctrl   = wr_pend & (wr_ofs == rsci_pkg::OFS_CTRL)
                   & (state == rsci_pkg::RSCI_RUN); // R06

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'h0;
      wr_ofs  <= rsci_pkg::OFS_CTRL;
    end else begin
      wr_pend <= ahb_take & hwrite & ahb_word;
      wr_ofs  <= ahb_ofs;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hub_configured <= 1'h0;
      hub_suspended  <= 1'h0;
    end else if (state != rsci_pkg::RSCI_RUN) begin
      hub_configured <= 1'h0; // R07
      hub_suspended  <= 1'h0;
    end else if (wr_ctrl) begin
      hub_configured <= hwdata[rsci_pkg::CTRL_CONF_BIT];
      hub_suspended  <= hwdata[rsci_pkg::CTRL_SUSP_BIT];
    end
  end

  always_comb begin
    ctrl_word = rsci_pkg::ZERO_WORD;
    // a read right behind a write sees the value being written
    if (wr_ctrl) begin
      ctrl_word[rsci_pkg::CTRL_CONF_BIT] = hwdata[rsci_pkg::CTRL_CONF_BIT];
      ctrl_word[rsci_pkg::CTRL_SUSP_BIT] = hwdata[rsci_pkg::CTRL_SUSP_BIT];
    end else begin
      ctrl_word[rsci_pkg::CTRL_CONF_BIT] = hub_configured;
      ctrl_word[rsci_pkg::CTRL_SUSP_BIT] = hub_suspended;
    end
  end

  always_comb begin
    status_word = rsci_pkg::ZERO_WORD;
    status_word[rsci_pkg::ST_CFG_LSB +: 3]    = config_method;
    status_word[rsci_pkg::ST_FIX_LSB +: 2]    = fixed_device_code;
    status_word[rsci_pkg::ST_STRAPEN_BIT]     = strap_enable;
    status_word[rsci_pkg::ST_NONREM_LSB +: 3] = non_removable_ports;
    status_word[rsci_pkg::ST_POLLOW_BIT]      = led_active_low;
    status_word[rsci_pkg::ST_SELFPWR_BIT]     = self_power;
    status_word[rsci_pkg::ST_DONE_BIT]        = capture_done;
    status_word[rsci_pkg::ST_SMB_BIT]         = smbus_slave_mode;
    status_word[rsci_pkg::ST_LED_BIT]         = hub_active_led;
    status_word[rsci_pkg::ST_SUPPLY_BIT]      = supply_ok;
  end

  always_comb begin
    smb_word = rsci_pkg::ZERO_WORD;
    if (smbus_slave_mode) begin
      smb_word[rsci_pkg::SMB_ADDR_LSB +: 7] = rsci_pkg::SMB_SLAVE_ADDR; // R16
      smb_word[rsci_pkg::SMB_EN_BIT]        = 1'h1;
    end
  end

  assign rd_value =
    (ahb_ofs == rsci_pkg::OFS_CTRL)   ? ctrl_word   :
    (ahb_ofs == rsci_pkg::OFS_STATUS) ? status_word :
    (ahb_ofs == rsci_pkg::OFS_SMB)    ? smb_word    :
                                        rsci_pkg::ZERO_WORD;

  // read data taken at the address phase, shown through the data phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= rsci_pkg::ZERO_WORD;
    end else if (ahb_take & ~hwrite) begin
      hrdata <= rd_value;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  capture_sel_a: assert property ( // R01
    state == rsci_pkg::RSCI_CAPTURE |=>
      config_method == $past(sel_now) && capture_done)
    else $error("select pins not latched at release");

  sel_hi_zero_a: assert property ( // R02
    !HAS_SEL_HI && capture_done |-> !config_method[2])
    else $error("absent high select read as one");

  supply_hold_a: assert property ( // R06
    !supply_ok |=> state == rsci_pkg::RSCI_HOLD ##1 !capture_done)
    else $error("logic left reset with supplies unstable");

  led_level_a: assert property ( // R07
    state == rsci_pkg::RSCI_RUN && hub_configured && !hub_suspended |=>
      hub_active_led == !$past(led_active_low))
    else $error("indicator not active while configured and awake");

  led_dark_a: assert property ( // R07
    capture_done && !hub_configured |=>
      hub_active_led == $past(led_active_low))
    else $error("indicator active while unconfigured");

  strap_gate_a: assert property ( // R09
    capture_done && !strap_enable |->
      fixed_device_code == rsci_pkg::FIX_NONE)
    else $error("straps used while disabled");

  nonrem_map_a: assert property ( // R10
    capture_done |-> non_removable_ports ==
      {fixed_device_code == rsci_pkg::FIX_P123,
       fixed_device_code[1],
       fixed_device_code != rsci_pkg::FIX_NONE}
      && led_active_low == fixed_device_code[rsci_pkg::FIX_POL_BIT])
    else $error("fixed-device decode wrong");

  method_decode_a: assert property ( // R15
    capture_done |-> strap_enable ==
      (config_method == rsci_pkg::CFG_DEFAULT ||
       config_method == rsci_pkg::CFG_DEFAULT_BUS)
      && smbus_slave_mode == (config_method == rsci_pkg::CFG_SMBUS))
    else $error("method code decode wrong");

  self_power_a: assert property ( // R08
    state == rsci_pkg::RSCI_CAPTURE |=>
      self_power == $past(selfpwr_now))
    else $error("self power not taken from pin");

  capture_frozen_a: assert property ( // R17
    capture_done && $past(capture_done) && supply_ok |->
      $stable(config_method) && $stable(fixed_device_code))
    else $error("captured straps changed after release");

  pin_quiet_a: assert property ( // R18
    !capture_done |-> !hub_active_led_oe)
    else $error("shared pin driven before strap capture");

endmodule

// file: rsci_board.sv
// rsci_board.sv: board around the strap block: strap resistors, reset
// source and the status led sharing the strap pin
// assumes: the bench sets strap levels and makes sys_clk
`timescale 1ns/1ps

module rsci_board (
  input  wire logic       sys_clk,
  input  wire logic       reset_req,
  input  wire logic [2:0] sel_strap,
  input  wire logic [1:0] fix_strap,
  input  wire logic       led_out,
  input  wire logic       led_oe,
  output logic            rstn,
  output logic [2:0]      sel_pin,
  output logic            strap_hi_pin,
  output logic            shared_pin
);
  int unsigned hold_cnt = 3;

  // ******************************************************************
  // reset source
  // ******************************************************************
  initial rstn = 1'b0;
  always @(posedge sys_clk) begin
    if (reset_req) begin
      hold_cnt <= rsci_pkg::RST_MIN_CYC;
      rstn     <= 1'b0;
    end else if (hold_cnt > 1) begin
      hold_cnt <= hold_cnt - 1;
    end else begin
      hold_cnt <= 0;
      rstn     <= 1'b1;
    end
  end

  // ******************************************************************
  // strap resistors; a released pin falls back to its resistor level
  // ******************************************************************
  assign sel_pin      = sel_strap;
  assign strap_hi_pin = fix_strap[1];
  assign shared_pin   = led_oe ? led_out : fix_strap[0];
endmodule

// file: tb.sv
// tb.sv: self-checking bench for the strap capture block
// assumes: rsci_board.sv models the board; no other stimulus source
`timescale 1ns/1ps

module tb;
  logic        sys_clk = 1'b0;
  logic        req = 1'b0, supply = 1'b1;
  logic [2:0]  sel = 3'h0;
  logic [1:0]  fixs = 2'h0;
  logic        rstn, pin, shi, led, oe, done, lal_o, sp, smb, se;
  logic [2:0]  selp, cm, nr, cm2;
  logic [1:0]  fdc;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  int          n_mismatch = 0, comparisons = 0, seed = 32235;
  logic [31:0] rnd;

  // ******************************************************************
  // clock, board and design
  // ******************************************************************
  initial forever #10 sys_clk = ~sys_clk;

  rsci_board rsci_board_i (.sys_clk(sys_clk), .reset_req(req),
    .sel_strap(sel), .fix_strap(fixs), .led_out(led), .led_oe(oe),
    .rstn(rstn), .sel_pin(selp), .strap_hi_pin(shi), .shared_pin(pin));

  rsci_strap_capture rsci_strap_capture_i (.sys_clk(sys_clk),
    .rstn(rstn), .supply_stable(supply),
    .config_method_select_hi(selp[2]), .config_method_select_mid(selp[1]),
    .config_method_select_lo(selp[0]), .fixed_device_strap_hi(shi),
    .self_power_detect(pin), .hub_active_led(led),
    .hub_active_led_oe(oe), .config_method(cm), .fixed_device_code(fdc),
    .non_removable_ports(nr), .led_active_low(lal_o), .self_power(sp),
    .smbus_slave_mode(smb), .strap_enable(se), .capture_done(done),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));

  // package without the high select pin, watched on its method only
  rsci_strap_capture #(.HAS_SEL_HI(1'b0)) rsci_strap_capture_lo_i (
    .sys_clk(sys_clk), .rstn(rstn), .supply_stable(supply),
    .config_method_select_hi(selp[2]), .config_method_select_mid(selp[1]),
    .config_method_select_lo(selp[0]), .fixed_device_strap_hi(shi),
    .self_power_detect(pin), .hub_active_led(), .hub_active_led_oe(),
    .config_method(cm2), .fixed_device_code(), .non_removable_ports(),
    .led_active_low(), .self_power(), .smbus_slave_mode(),
    .strap_enable(), .capture_done(), .hsel(1'b0), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(), .hresp(), .hrdata());

  // ******************************************************************
  // expectations and bus tasks
  // ******************************************************************
  function automatic logic [1:0] exp_code(input logic [2:0] c,
                                          input logic [1:0] f);
    exp_code = (c == 3'h0 || c == 3'h2) ? f : 2'h0;
  endfunction

  function automatic logic [2:0] exp_nr(input logic [1:0] k);
    case (k)
      2'h0: exp_nr = 3'h0;
      2'h1: exp_nr = 3'h1;
      2'h2: exp_nr = 3'h3;
      default: exp_nr = 3'h7;
    endcase
  endfunction

  function automatic logic [31:0] exp_st(input logic [2:0] c,
                                         input logic [1:0] f);
    logic [1:0] k;
    k = exp_code(c, f);
    exp_st = {17'h0_0000, 1'b1, k[0], c == 3'h1, 1'b1,
              (c != 3'h2) & f[0], k[0], exp_nr(k),
              c == 3'h0 || c == 3'h2, k, c};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic run(input logic [2:0] c, input logic [1:0] f);
    logic [31:0] rd;
    logic [1:0]  k;
    k = exp_code(c, f);
    @(posedge sys_clk);
    sel  <= c;
    fixs <= f;
    req  <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    chk("done in reset", 32'h0, {31'h0, done});
    chk("oe in reset", 32'h0, {31'h0, oe});
    while (rstn !== 1'b1) @(posedge sys_clk);
    while (done !== 1'b1) begin
      chk("oe before capture", 32'h0, {31'h0, oe});
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    rnd = $random(seed);
    sel  <= rnd[2:0];
    fixs <= rnd[4:3];
    chk("method", {29'h0, c}, {29'h0, cm});
    chk("method no hi pin", {30'h0, c[1:0]}, {29'h0, cm2});
    chk("fixed code", {30'h0, k}, {30'h0, fdc});
    chk("non removable", {29'h0, exp_nr(k)}, {29'h0, nr});
    chk("led low", {31'h0, k[0]}, {31'h0, lal_o});
    chk("strap en", {31'h0, c == 3'h0 || c == 3'h2}, {31'h0, se});
    chk("smbus", {31'h0, c == 3'h1}, {31'h0, smb});
    chk("self power", {31'h0, (c != 3'h2) & f[0]}, {31'h0, sp});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
    repeat (3) @(posedge sys_clk);
    chk("led on", {31'h0, ~k[0]}, {31'h0, pin});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0003, rd);
    repeat (3) @(posedge sys_clk);
    chk("led suspended", {31'h0, k[0]}, {31'h0, pin});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
    chk("status", exp_st(c, f), rd);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
    chk("smb reg", (c == 3'h1) ? 32'h0000_00ac : 32'h0, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ******************************************************************
  // sequence: every strap pair, then random pairs, then supply loss
  // ******************************************************************
  initial begin
    for (int i = 0; i < 32; i++) begin
      run(i[4:2], i[1:0]);
    end
    repeat (8) begin
      rnd = $random(seed);
      run(rnd[2:0], rnd[4:3]);
    end
    @(posedge sys_clk);
    supply <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("done no supply", 32'h0, {31'h0, done});
    chk("oe no supply", 32'h0, {31'h0, oe});
    supply <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("done supply back", 32'h1, {31'h0, done});
    end_of_test();
  end

  // a full run takes about 3500 cycles
  initial begin
    #(20 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule
